// file: rtl/ivc_pkg.sv
// Package: constants and types for the interrupt vector and context stack
package ivc_pkg;

	// ----------------------------------------
	// Bus and register map
	// ----------------------------------------
	localparam int unsigned AXI_AW = 8;
	localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] ADDR_DEPTH = 8'h08;
	localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h0C;
	localparam logic [AXI_AW-1:0] ADDR_MASK = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// CTRL fields
	localparam int unsigned CTRL_FAULT_EN_BIT = 0;
	localparam int unsigned CTRL_LOCKED_BIT = 1;

	// Event bits in STATUS and MASK
	localparam int unsigned EV_W = 3;
	localparam int unsigned EV_DISCARD = 0;
	localparam int unsigned EV_FAULT_RESET = 1;
	localparam int unsigned EV_UNDERFLOW = 2;

	// ----------------------------------------
	// Sources, vectors and depth pointer
	// ----------------------------------------
	localparam int unsigned NUM_SRC = 12;
	localparam int unsigned SRC_IDX_W = 4;
	localparam int unsigned VEC_W = 14;
	localparam logic [VEC_W-1:0] VEC_TOP = 14'h000C;
	localparam logic [VEC_W-1:0] VEC_BOTTOM = 14'h0001;
	localparam int unsigned DEPTH_LEVELS = 4;
	localparam int unsigned DEPTH_W = 3;
	localparam logic [DEPTH_W-1:0] PTR_EMPTY = 3'h5;
	localparam logic [DEPTH_W-1:0] PTR_FULL = 3'h1;
	localparam logic [DEPTH_W-1:0] PTR_BAD = 3'h0;

	// ----------------------------------------
	// Saved system register set
	// ----------------------------------------
	localparam int unsigned WIN_W = 4;
	localparam int unsigned BANK_W = 4;
	localparam int unsigned IDX_W = 12;
	localparam int unsigned GP_W = 7;
	localparam int unsigned PSW_W = 4;

	typedef struct packed {
		logic [WIN_W-1:0] window;
		logic [BANK_W-1:0] bank;
		logic [IDX_W-1:0] index_reg;
		logic [GP_W-1:0] general_pointer_reg;
		logic [PSW_W-1:0] program_status_word;
	} ivc_ctx_s;

endpackage

// file: rtl/ivc_vector_gen.sv
// Fixed-priority pick of the accepted source and its branch target
`timescale 1ns/1ns
`default_nettype none

module ivc_vector_gen
	import ivc_pkg::*;
#(
	parameter int unsigned N = NUM_SRC
) (
	input wire logic [N-1:0] pending_i,
	output logic any_o,
	output logic [SRC_IDX_W-1:0] index_o,
	output logic [VEC_W-1:0] vector_o
);

	// Bit 0 is the CE falling edge, highest priority; scan from the high end down so the lowest set bit wins
	always_comb begin
		any_o = 1'b0;
		index_o = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pending_i[i]) begin
				any_o = 1'b1;
				index_o = SRC_IDX_W'(i);
			end
		end
	end

	// One step down per source below the CE target
	assign vector_o = VEC_TOP - VEC_W'(index_o);

endmodule // ivc_vector_gen

`default_nettype wire

// file: rtl/ivc_top.sv
// Top: interrupt vector target and four-level context save stack with AXI4-Lite registers
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ivc_top
	import ivc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Core side
	input wire logic [NUM_SRC-1:0] pending_i,
	input wire logic accept_i,
	input wire logic interrupt_return_instr_i,
	input wire ivc_ctx_s ctx_i,
	input wire logic wdt_reset_i,
	input wire logic ce_reset_i,
	output logic vector_valid_o,
	output logic [VEC_W-1:0] vector_o,
	output logic [SRC_IDX_W-1:0] source_o,
	output logic clear_sys_o,
	output logic restore_valid_o,
	output ivc_ctx_s restore_ctx_o,
	output logic sys_reset_o,
	output logic irq_o,
	// AXI4-Lite slave
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	logic sel_any;
	logic [SRC_IDX_W-1:0] sel_index;
	logic [VEC_W-1:0] sel_vector;

	ivc_vector_gen #(
		.N(NUM_SRC)
	) u_vector_gen (
		.pending_i(pending_i),
		.any_o(sel_any),
		.index_o(sel_index),
		.vector_o(sel_vector)
	);

	logic push;
	logic pop;
	logic [DEPTH_W-1:0] ptr_q;
	logic [1:0] top_q;
	logic fault_en_q;
	logic locked_q;
	logic sys_reset_q;
	logic stack_full;
	logic stack_empty;
	logic overflow_fault;
	logic underflow;
	logic soft_reset;

	// Push wins if the core ever signals both in one cycle
	assign push = accept_i && sel_any;
	assign pop = interrupt_return_instr_i && !push;
	assign stack_full = (ptr_q == PTR_FULL);
	assign stack_empty = (ptr_q == PTR_EMPTY);
	assign overflow_fault = push && stack_full && fault_en_q;
	assign underflow = pop && stack_empty;
	assign soft_reset = wdt_reset_i || sys_reset_q;

	// ----------------------------------------
	// Vector issue
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vector_valid_o <= 1'b0;
			vector_o <= '0;
			source_o <= '0;
			clear_sys_o <= 1'b0;
		end else begin
			vector_valid_o <= push;
			clear_sys_o <= push;
			if (push) begin
				vector_o <= sel_vector;
				source_o <= sel_index;
			end
		end
	end

	// ----------------------------------------
	// Context storage
	// ----------------------------------------
	// No reset on the entries: their content is unknown until first written
	ivc_ctx_s stack_mem [DEPTH_LEVELS];

	always_ff @(posedge clock_i) begin
		if (push) begin
			stack_mem[top_q] <= ctx_i;
		end
	end

	// Ring index; a fifth push lands on the oldest slot
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			top_q <= '0;
		end else if (soft_reset || ce_reset_i) begin
			top_q <= '0;
		end else if (push) begin
			top_q <= top_q + 2'h1;
		end else if (pop && !stack_empty) begin
			top_q <= top_q - 2'h1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			restore_valid_o <= 1'b0;
			restore_ctx_o <= '0;
		end else begin
			restore_valid_o <= pop && !stack_empty;
			if (pop && !stack_empty) begin
				restore_ctx_o <= stack_mem[top_q - 2'h1];
			end
		end
	end

	// ----------------------------------------
	// Depth pointer
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_q <= PTR_EMPTY;
		end else if (soft_reset || ce_reset_i) begin
			ptr_q <= PTR_EMPTY;
		end else if (push && !stack_full) begin
			ptr_q <= ptr_q - 3'h1;
		end else if (pop && !stack_empty) begin
			ptr_q <= ptr_q + 3'h1;
		end
	end

	// ----------------------------------------
	// Fault reset flag and system reset
	// ----------------------------------------
	logic wr_go;
	logic [AXI_AW-1:0] wr_addr_q;
	logic [31:0] wr_data_q;
	logic [3:0] wr_strb_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_en_q <= 1'b1;
			locked_q <= 1'b0;
		end else if (soft_reset) begin
			fault_en_q <= 1'b1;
			locked_q <= 1'b0;
		end else if (wr_go && wr_addr_q == ADDR_CTRL && wr_strb_q[0] && !locked_q) begin
			fault_en_q <= wr_data_q[CTRL_FAULT_EN_BIT];
			locked_q <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_reset_q <= 1'b0;
		end else begin
			sys_reset_q <= !sys_reset_q && (overflow_fault || (underflow && fault_en_q));
		end
	end
	assign sys_reset_o = sys_reset_q;

	// ----------------------------------------
	// Event status, mask and interrupt
	// ----------------------------------------
	logic [EV_W-1:0] status_q;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_clr;

	always_comb begin
		ev_set = '0;
		ev_set[EV_DISCARD] = push && stack_full && !fault_en_q;
		ev_set[EV_FAULT_RESET] = sys_reset_q;
		ev_set[EV_UNDERFLOW] = underflow;
		ev_clr = '0;
		if (wr_go && wr_addr_q == ADDR_STATUS && wr_strb_q[0]) begin
			ev_clr = wr_data_q[EV_W-1:0];
		end
	end

	// Set beats a clear that lands in the same cycle
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~ev_clr) | ev_set;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_q <= '0;
		end else if (wr_go && wr_addr_q == ADDR_MASK && wr_strb_q[0]) begin
			mask_q <= wr_data_q[EV_W-1:0];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(((status_q & ~ev_clr) | ev_set) & mask_q);
		end
	end

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	logic aw_have_q;
	logic w_have_q;

	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_have_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			wr_addr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_have_q <= 1'b0;
			wr_data_q <= '0;
			wr_strb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wr_data_q <= s_axi_wdata;
			wr_strb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	// Depth pointer writes answer OKAY and change nothing
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			case (wr_addr_q)
				ADDR_CTRL, ADDR_DEPTH, ADDR_STATUS, ADDR_MASK: begin
					s_axi_bresp <= RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL: begin
					s_axi_rdata[CTRL_FAULT_EN_BIT] <= fault_en_q;
					s_axi_rdata[CTRL_LOCKED_BIT] <= locked_q;
				end
				ADDR_DEPTH: begin
					s_axi_rdata[DEPTH_W-1:0] <= ptr_q;
				end
				ADDR_STATUS: begin
					s_axi_rdata[EV_W-1:0] <= status_q;
				end
				ADDR_MASK: begin
					s_axi_rdata[EV_W-1:0] <= mask_q;
				end
				default: begin
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	vector_issue_a: assert property (push |=> vector_valid_o && vector_o == VEC_TOP - VEC_W'($past(sel_index)))
		else $error("vector not issued for accepted source");

	vector_range_a: assert property (vector_valid_o |-> vector_o <= VEC_TOP && vector_o >= VEC_BOTTOM)
		else $error("vector outside the source range");

	ce_first_a: assert property (accept_i && pending_i[0] |=> vector_o == VEC_TOP)
		else $error("CE edge not taken first");

	clear_follow_a: assert property (push |=> clear_sys_o ##1 !clear_sys_o || $past(push))
		else $error("system register clear missing");

	ptr_step_a: assert property (push && !stack_full && !soft_reset && !ce_reset_i |=> ptr_q == $past(ptr_q) - 3'h1)
		else $error("pointer did not step down on push");

	ptr_legal_a: assert property (ptr_q != PTR_BAD && ptr_q <= PTR_EMPTY)
		else $error("depth pointer took an illegal code");

	overflow_reset_a: assert property (overflow_fault && !sys_reset_q |=> sys_reset_o ##1 !sys_reset_o)
		else $error("fifth level did not raise one reset pulse");

	discard_hold_a: assert property (push && stack_full && !fault_en_q && !soft_reset && !ce_reset_i |=> ptr_q == PTR_FULL)
		else $error("pointer moved on discard");

	pop_restore_a: assert property (pop && !stack_empty |=> restore_valid_o)
		else $error("return did not restore a context");

	write_once_a: assert property (locked_q && !soft_reset |=> $stable(fault_en_q))
		else $error("fault reset flag changed after its one write");

	nest_full_c: cover property (push && ptr_q == PTR_FULL);
	push_pop_c: cover property (push ##[1:20] pop);
	underflow_c: cover property (underflow);
	axi_read_c: cover property (s_axi_rvalid && s_axi_rready);

endmodule // ivc_top

`default_nettype wire

// file: sim/ivc_core_model.sv
// Core model: system registers that the context stack saves and restores
`timescale 1ns/1ns
`default_nettype none

module ivc_core_model
	import ivc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire ivc_ctx_s load_ctx_i,
	input wire logic clear_sys_i,
	input wire logic restore_valid_i,
	input wire ivc_ctx_s restore_ctx_i,
	output var ivc_ctx_s ctx_o
);
	// ----------------------------------------
	// System registers
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctx_o <= '0;
		end else if (load_i) begin
			ctx_o <= load_ctx_i;
		end else if (clear_sys_i) begin
			// Window survives the entry clear
			ctx_o <= {ctx_o.window, {($bits(ivc_ctx_s) - WIN_W){1'b0}}};
		end else if (restore_valid_i) begin
			ctx_o <= restore_ctx_i;
		end
	end
endmodule // ivc_core_model

`default_nettype wire

// file: sim/ivc_top_bench.sv
// Testbench for the vector target and context stack block
`timescale 1ns/1ns
`default_nettype none

module ivc_top_bench
	import ivc_pkg::*;
;
	logic clock_i, rst_n_i, acc, ret_instr, wdt, ce, ld;
	logic [NUM_SRC-1:0] pend;
	ivc_ctx_s ctx, ld_ctx, rctx;
	logic vv, clr, rv, sr, irq, awv, awr, wv, wr, bv, br, arv, arr, rvl, rr;
	logic [VEC_W-1:0] vec;
	logic [SRC_IDX_W-1:0] src;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdq, rdat;
	logic [3:0] ws;
	logic [1:0] bresp, rresp, resp;
	int fails, samples_checked, vv_n, rv_n, sr_n, cyc;

	ivc_top u_ivc_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .pending_i(pend), .accept_i(acc),
		.interrupt_return_instr_i(ret_instr), .ctx_i(ctx), .wdt_reset_i(wdt),
		.ce_reset_i(ce), .vector_valid_o(vv),
		.vector_o(vec), .source_o(src), .clear_sys_o(clr), .restore_valid_o(rv),
		.restore_ctx_o(rctx), .sys_reset_o(sr), .irq_o(irq), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdq), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr));

	ivc_core_model u_ivc_core_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_i(ld),
		.load_ctx_i(ld_ctx), .clear_sys_i(clr), .restore_valid_i(rv), .restore_ctx_i(rctx),
		.ctx_o(ctx));

	// ----------------------------------------
	// Clock, event counters and timeout
	// ----------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		vv_n += (vv === 1'b1);
		rv_n += (rv === 1'b1);
		sr_n += (sr === 1'b1);
		cyc++;
		if (cyc == 20000) begin
			fails++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic ivc_ctx_s mk(input int i);
		return ivc_ctx_s'(31'(32'h1357_9BDF * (i + 1)));
	endfunction

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		awa <= a;
		wd <= d;
		ws <= 4'hF;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		#1;
		while (awv || wv) begin
			@(posedge clock_i);
			if (awr === 1'b1) awv <= 1'b0;
			if (wr === 1'b1) wv <= 1'b0;
		end
		while (bv !== 1'b1) @(posedge clock_i);
		resp = bresp;
		br <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock_i);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge clock_i); while (arr !== 1'b1);
		arv <= 1'b0;
		while (rvl !== 1'b1) @(posedge clock_i);
		rdat = rdq;
		resp = rresp;
		rr <= 1'b0;
	endtask

	// Request flags drop once the source is accepted
	task automatic push(input logic [NUM_SRC-1:0] p, input ivc_ctx_s c);
		@(posedge clock_i);
		pend <= p;
		ld <= 1'b1;
		ld_ctx <= c;
		@(posedge clock_i);
		ld <= 1'b0;
		acc <= 1'b1;
		@(posedge clock_i);
		acc <= 1'b0;
		pend <= '0;
		repeat (2) @(posedge clock_i);
		#1;
	endtask

	task automatic pop();
		@(posedge clock_i);
		ret_instr <= 1'b1;
		@(posedge clock_i);
		ret_instr <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
	endtask

	// One-cycle reset request: CE reset when use_ce, watchdog otherwise
	task automatic pulse(input bit use_ce);
		@(posedge clock_i);
		if (use_ce) ce <= 1'b1;
		else wdt <= 1'b1;
		@(posedge clock_i);
		ce <= 1'b0;
		wdt <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd_reg(ADDR_DEPTH);
		chk("depth", 32'h0000_0005, rdat);
		rd_reg(ADDR_CTRL);
		chk("fault_en", 32'h0000_0001, rdat & 32'h1);
		wr_reg(ADDR_DEPTH, 32'h0000_0000);
		chk("wresp", RESP_OKAY, resp);
		rd_reg(ADDR_DEPTH);
		chk("depth_ro", 32'h0000_0005, rdat);
		rd_reg(8'h20);
		chk("unmapped", RESP_SLVERR, resp);
		wr_reg(8'h20, 32'h0000_0000);
		chk("wr_unmapped", RESP_SLVERR, resp);
		$display("t_reset done");
	endtask

	task automatic t_vectors();
		ivc_ctx_s c;
		int n;
		for (int k = 0; k < NUM_SRC; k++) begin
			c = ivc_ctx_s'({4'(k), 4'hA, 12'h05A5, 7'h33, 4'h9});
			n = vv_n;
			push(12'hFFF << k, c);
			chk("vv", n + 1, vv_n);
			chk("vector", VEC_TOP - k, vec);
			chk("source", k, src);
			chk("cleared", {c.window, 27'h0}, ctx);
			pop();
			chk("restored", c, ctx);
		end
		$display("t_vectors done");
	endtask

	task automatic t_nest();
		for (int i = 0; i < 4; i++) begin
			push(12'h800, mk(i));
			rd_reg(ADDR_DEPTH);
			chk("depth_push", 4 - i, rdat);
		end
		for (int i = 3; i >= 0; i--) begin
			pop();
			chk("lifo", mk(i), ctx);
			rd_reg(ADDR_DEPTH);
			chk("depth_pop", 5 - i, rdat);
		end
		$display("t_nest done");
	endtask

	task automatic t_discard();
		int n;
		int m;
		wr_reg(ADDR_CTRL, 32'h0000_0000);
		wr_reg(ADDR_CTRL, 32'h0000_0001);
		rd_reg(ADDR_CTRL);
		chk("write_once", 32'h0, rdat & 32'h1);
		wr_reg(ADDR_MASK, 32'h0000_0000);
		for (int i = 0; i < 5; i++) push(12'h001, mk(i));
		rd_reg(ADDR_DEPTH);
		chk("depth_full", 32'h0000_0001, rdat);
		rd_reg(ADDR_STATUS);
		chk("discard_ev", 32'h1, rdat & 32'h1);
		chk("irq_masked", 32'h0, irq);
		wr_reg(ADDR_MASK, 32'h0000_0007);
		rd_reg(ADDR_MASK);
		chk("mask", 32'h0000_0007, rdat);
		chk("irq_on", 32'h1, irq);
		for (int i = 4; i > 0; i--) begin
			pop();
			chk("kept", mk(i), ctx);
		end
		n = sr_n;
		m = rv_n;
		pop();
		rd_reg(ADDR_STATUS);
		chk("underflow_ev", 32'h4, rdat & 32'h4);
		chk("no_reset", n, sr_n);
		chk("no_restore", m, rv_n);
		wr_reg(ADDR_STATUS, 32'h0000_0007);
		rd_reg(ADDR_STATUS);
		chk("w1c", 32'h0, rdat);
		chk("irq_off", 32'h0, irq);
		$display("t_discard done");
	endtask

	task automatic t_fault();
		int n;
		pulse(1'b0);
		rd_reg(ADDR_CTRL);
		chk("flag_back", 32'h1, rdat & 32'h1);
		n = sr_n;
		for (int i = 0; i < 5; i++) push(12'h400, mk(i));
		chk("ovf_reset", n + 1, sr_n);
		rd_reg(ADDR_DEPTH);
		chk("depth_rst", 32'h0000_0005, rdat);
		pop();
		chk("unf_reset", n + 2, sr_n);
		$display("t_fault done");
	endtask

	task automatic t_ce();
		push(12'h002, mk(1));
		push(12'h002, mk(2));
		pulse(1'b1);
		rd_reg(ADDR_DEPTH);
		chk("depth_ce", 32'h0000_0005, rdat);
		$display("t_ce done");
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		{rst_n_i, acc, ret_instr, wdt, ce, ld, pend, ld_ctx} = '0;
		{awv, wv, br, arv, rr, awa, ara, wd, ws} = '0;
		{fails, samples_checked, vv_n, rv_n, sr_n, cyc} = '0;
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_vectors();
		t_nest();
		t_discard();
		t_fault();
		t_ce();
		wrap_up();
	end
endmodule // ivc_top_bench

`default_nettype wire
